// ===== core/tdc_regs.v
// Overview of operation
// - Channel B gain trim, 8 bits at 0x7B, fuse default, read/write.
// - Band-gap trim in bits 3:0 at 0x7C, fuse default; bits 7:4 reserved.
// - Input A termination trim, 8 bits at 0x7E, fuse default, read/write.
// - Input B termination trim, 8 bits at 0x7F, fuse default, read/write.
// - Dither control at 0x9D, fields in bits 2:0, 7:3 reserved, fuse default.
// - Dither enable, bit 0, resets to one; set injects dither.
// - Dither size select, bit 1, resets zero; zero small, one large.
// - Rounding error select, bit 2, resets zero; zero noise, one offset/spurs.
`include "tdc_map.vh"

module tdc_regs #(
  parameter SETTLE = `TDC_FUSE_SETTLE_CYC
) (
  input wire pclk, // APB clock, 100 MHz
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction, high writes
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  input wire [3:0] pstrb, // APB byte strobes
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error, unmapped address
  input wire [7:0] fuse_gain_a, // Fuse default, gain A
  input wire [7:0] fuse_gain_b, // Fuse default, gain B
  input wire [3:0] fuse_bandgap, // Fuse default, band-gap
  input wire [7:0] fuse_term_a, // Fuse default, termination A
  input wire [7:0] fuse_term_b, // Fuse default, termination B
  input wire [2:0] fuse_dither, // Fuse default, dither fields
  output reg [7:0] chan_a_gain_adjust, // Gain trim to analog_input_a
  output reg [7:0] chan_b_gain_adjust, // Gain trim to analog_input_b
  output reg [3:0] bandgap_adjust, // Band-gap reference trim
  output reg [7:0] input_a_termination_adjust, // Termination trim A
  output reg [7:0] input_b_termination_adjust, // Termination trim B
  output reg dither_enable, // Dither injection on
  output reg dither_size_select, // High selects large dither
  output reg rounding_error_select, // High sends error to offset/spurs
  output reg fuse_busy // Fuse word not yet applied
);

  // Register select codes
  localparam SEL_NONE = 3'd0;
  localparam SEL_GAIN_A = 3'd1;
  localparam SEL_GAIN_B = 3'd2;
  localparam SEL_BG = 3'd3;
  localparam SEL_TERM_A = 3'd4;
  localparam SEL_TERM_B = 3'd5;
  localparam SEL_DITH = 3'd6;
  localparam SEL_STAT = 3'd7;

  localparam FW = 2 * `TDC_TRIM_W + `TDC_BG_W + 2 * `TDC_TRIM_W + `TDC_DITH_W;
  localparam [2:0] RST_DITH = `TDC_RST_DITHER;

  wire [FW-1:0] fuse_bus;
  wire [FW-1:0] fuse_word;
  wire load_pulse;
  wire loader_busy;
  reg reload_q;
  reg [5:0] modified_q;
  reg [5:0] modified_d;
  reg [2:0] sel;
  reg reload_hit;
  wire setup_ok;
  wire commit;
  wire wr_commit;
  wire lane0;

  // Map a word address to a select code; misaligned never matches
  function [2:0] tdc_decode;
    input [11:0] addr;
    begin
      tdc_decode = SEL_NONE;
      if (addr[1:0] == 2'b00) begin
        case (addr[11:2])
          `TDC_IDX_GAIN_A: tdc_decode = SEL_GAIN_A;
          `TDC_IDX_GAIN_B: tdc_decode = SEL_GAIN_B;
          `TDC_IDX_BANDGAP: tdc_decode = SEL_BG;
          `TDC_IDX_TERM_A: tdc_decode = SEL_TERM_A;
          `TDC_IDX_TERM_B: tdc_decode = SEL_TERM_B;
          `TDC_IDX_DITHER: tdc_decode = SEL_DITH;
          `TDC_IDX_STATUS: tdc_decode = SEL_STAT;
          default: tdc_decode = SEL_NONE;
        endcase
      end
    end
  endfunction

  // Reload control is write-only and reads as zero
  function tdc_is_reload;
    input [11:0] addr;
    begin
      tdc_is_reload = (addr[1:0] == 2'b00) && (addr[11:2] == `TDC_IDX_RELOAD);
    end
  endfunction

  // Fuse inputs travel as one word through the settling loader
  assign fuse_bus = {fuse_gain_a, fuse_gain_b, fuse_bandgap,
                     fuse_term_a, fuse_term_b, fuse_dither};

  tdc_fuse_sync #(
    .W(FW),
    .SETTLE(SETTLE)
  ) u_fuse (
    .pclk(pclk),
    .presetn(presetn),
    .fuse_in(fuse_bus),
    .reload(reload_q),
    .fuse_word(fuse_word),
    .load_pulse(load_pulse),
    .busy(loader_busy)
  );

  // Decode once for the current request
  always @* begin
    sel = tdc_decode(paddr);
    reload_hit = tdc_is_reload(paddr);
  end

  // Answer held off while the fuse word is pending or landing, so reads see loaded fields
  assign setup_ok = psel && penable && !pready && !loader_busy && !load_pulse && !reload_q;
  assign commit = psel && penable && pready;
  assign wr_commit = commit && pwrite && !pslverr;
  assign lane0 = pstrb[0];

  // APB answer: one wait state, read data captured with ready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ok;
      if (setup_ok) begin
        pslverr <= (sel == SEL_NONE) && !reload_hit;
        prdata <= 32'h0000_0000;
        if (!pwrite) begin
          case (sel)
            SEL_GAIN_A: prdata[7:0] <= chan_a_gain_adjust;
            SEL_GAIN_B: prdata[7:0] <= chan_b_gain_adjust;
            SEL_BG: prdata[3:0] <= bandgap_adjust;
            SEL_TERM_A: prdata[7:0] <= input_a_termination_adjust;
            SEL_TERM_B: prdata[7:0] <= input_b_termination_adjust;
            SEL_DITH: prdata[2:0] <= {rounding_error_select,
                                      dither_size_select,
                                      dither_enable};
            SEL_STAT: begin
              prdata[`TDC_STAT_BUSY_BIT] <= loader_busy;
              prdata[`TDC_STAT_MOD_LSB + 5:`TDC_STAT_MOD_LSB] <= modified_q;
            end
            default: prdata <= 32'h0000_0000;
          endcase
        end
      end else begin
        pslverr <= 1'b0; // Falls with pready
      end
    end
  end

  // Reload request is a single-cycle pulse to the loader
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= 1'b0;
    end else begin
      reload_q <= wr_commit && lane0 && reload_hit && pwdata[`TDC_RELOAD_BIT];
    end
  end

  // Gain trims: fuse load first, a committed write overrides the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_a_gain_adjust <= `TDC_RST_TRIM;
      chan_b_gain_adjust <= `TDC_RST_TRIM;
    end else begin
      if (load_pulse) begin
        chan_a_gain_adjust <= fuse_word[38:31];
        chan_b_gain_adjust <= fuse_word[30:23];
      end
      if (wr_commit && lane0 && sel == SEL_GAIN_A) begin
        chan_a_gain_adjust <= pwdata[7:0];
      end
      if (wr_commit && lane0 && sel == SEL_GAIN_B) begin
        chan_b_gain_adjust <= pwdata[7:0];
      end
    end
  end

  // Band-gap trim keeps only the low nibble; upper bits are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bandgap_adjust <= `TDC_RST_BG;
    end else begin
      if (load_pulse) begin
        bandgap_adjust <= fuse_word[22:19];
      end
      if (wr_commit && lane0 && sel == SEL_BG) begin
        bandgap_adjust <= pwdata[3:0];
      end
    end
  end

  // Termination trims for both inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_a_termination_adjust <= `TDC_RST_TRIM;
      input_b_termination_adjust <= `TDC_RST_TRIM;
    end else begin
      if (load_pulse) begin
        input_a_termination_adjust <= fuse_word[18:11];
        input_b_termination_adjust <= fuse_word[10:3];
      end
      if (wr_commit && lane0 && sel == SEL_TERM_A) begin
        input_a_termination_adjust <= pwdata[7:0];
      end
      if (wr_commit && lane0 && sel == SEL_TERM_B) begin
        input_b_termination_adjust <= pwdata[7:0];
      end
    end
  end

  // Dither fields: enable on, small size, error to noise until fuses land
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dither_enable <= RST_DITH[`TDC_DITH_EN_BIT];
      dither_size_select <= RST_DITH[`TDC_DITH_SIZE_BIT];
      rounding_error_select <= RST_DITH[`TDC_DITH_ERR_BIT];
    end else begin
      if (load_pulse) begin
        dither_enable <= fuse_word[`TDC_DITH_EN_BIT];
        dither_size_select <= fuse_word[`TDC_DITH_SIZE_BIT];
        rounding_error_select <= fuse_word[`TDC_DITH_ERR_BIT];
      end
      if (wr_commit && lane0 && sel == SEL_DITH) begin
        dither_enable <= pwdata[`TDC_DITH_EN_BIT];
        dither_size_select <= pwdata[`TDC_DITH_SIZE_BIT];
        rounding_error_select <= pwdata[`TDC_DITH_ERR_BIT];
      end
    end
  end

  // Fields written since last load, even with the fuse value; a write beats the load clear
  always @* begin
    modified_d = load_pulse ? 6'b00_0000 : modified_q;
    if (wr_commit && lane0) begin
      case (sel)
        SEL_GAIN_A: modified_d[0] = 1'b1;
        SEL_GAIN_B: modified_d[1] = 1'b1;
        SEL_BG: modified_d[2] = 1'b1;
        SEL_TERM_A: modified_d[3] = 1'b1;
        SEL_TERM_B: modified_d[4] = 1'b1;
        SEL_DITH: modified_d[5] = 1'b1;
        default: modified_d = modified_d;
      endcase
    end
  end

  // Status flags and a registered copy of loader activity
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modified_q <= 6'b00_0000;
      fuse_busy <= 1'b1;
    end else begin
      modified_q <= modified_d;
      fuse_busy <= loader_busy;
    end
  end

endmodule

// ===== core/tdc_map.vh
`ifndef TDC_MAP_VH
`define TDC_MAP_VH

// Register indices; byte address is four times the index
`define TDC_IDX_GAIN_A 10'h07A
`define TDC_IDX_GAIN_B 10'h07B
`define TDC_IDX_BANDGAP 10'h07C
`define TDC_IDX_TERM_A 10'h07E
`define TDC_IDX_TERM_B 10'h07F
`define TDC_IDX_DITHER 10'h09D
`define TDC_IDX_STATUS 10'h0A0
`define TDC_IDX_RELOAD 10'h0A1

// Field widths and positions
`define TDC_TRIM_W 8
`define TDC_BG_W 4
`define TDC_DITH_W 3
`define TDC_DITH_EN_BIT 0
`define TDC_DITH_SIZE_BIT 1
`define TDC_DITH_ERR_BIT 2
`define TDC_STAT_BUSY_BIT 0
`define TDC_STAT_MOD_LSB 8
`define TDC_RELOAD_BIT 0

// Values before the fuse word lands
`define TDC_RST_TRIM 8'h00
`define TDC_RST_BG 4'h0
`define TDC_RST_DITHER 3'h1

// Fuse word must hold still this long before it is taken
`define TDC_FUSE_SETTLE_NS 100
`define TDC_CLK_PERIOD_NS 10
`define TDC_FUSE_SETTLE_CYC ((`TDC_FUSE_SETTLE_NS + `TDC_CLK_PERIOD_NS - 1) / `TDC_CLK_PERIOD_NS)

`endif

// ===== core/tdc_fuse_sync.v
`include "tdc_map.vh"

module tdc_fuse_sync #(
  parameter W = 39,
  parameter SETTLE = `TDC_FUSE_SETTLE_CYC
) (
  input wire pclk, // Bus clock
  input wire presetn, // Async reset, active low
  input wire [W-1:0] fuse_in, // Raw fuse storage outputs
  input wire reload, // One-cycle request to fetch again
  output reg [W-1:0] fuse_word, // Settled fuse word
  output reg load_pulse, // One cycle: fuse_word is fresh
  output reg busy // High until the word is taken
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [7:0] cnt_q;
  reg [1:0] fill_q;
  wire stable;

  // Three stages; only s2 and s3 are compared, s1 feeds s2 alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= fuse_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Stages leave reset equal; with a short settle count the zeros would be taken as the fuse word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q <= 2'h0;
    end else if (fill_q != 2'h3) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  assign stable = (s2_q == s3_q) && (fill_q == 2'h3);

  // Wait for a quiet fuse bus, then take it once; reload starts over
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      busy <= 1'b1;
      load_pulse <= 1'b0;
      fuse_word <= {W{1'b0}};
    end else begin
      load_pulse <= 1'b0;
      if (reload) begin
        busy <= 1'b1;
        cnt_q <= 8'h00;
      end else if (busy) begin
        if (!stable) begin
          cnt_q <= 8'h00;
        end else if (cnt_q >= SETTLE[7:0] - 8'h01) begin
          fuse_word <= s3_q;
          load_pulse <= 1'b1;
          busy <= 1'b0;
          cnt_q <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

endmodule

// ===== verification/tdc_regs_monitor.sv
module tdc_regs_monitor (
  input logic pclk, // Clock
  input logic presetn, // Reset, active low
  input logic psel, // Select
  input logic penable, // Access phase
  input logic pwrite, // Direction
  input logic [11:0] paddr, // Byte address
  input logic [31:0] pwdata, // Write data
  input logic [3:0] pstrb, // Strobes
  input logic [31:0] prdata, // Read data
  input logic pready, // Ready
  input logic pslverr, // Error
  input logic [7:0] fuse_gain_b, // Fuse gain B
  input logic [7:0] chan_a_gain_adjust, // Gain A
  input logic [7:0] chan_b_gain_adjust, // Gain B
  input logic [3:0] bandgap_adjust, // Band-gap
  input logic dither_enable, // Dither on
  input logic dither_size_select, // Dither size
  input logic rounding_error_select, // Error routing
  input logic fuse_busy // Loader busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A completed, accepted write to one address
  sequence s_wr_at(a);
    pready && pwrite && !pslverr && pstrb[0] && paddr == a;
  endsequence

  pready_one_cycle_a: assert property (pready |=> !pready) else $error("pready held");
  pready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  // Loader takes about fourteen cycles, so forty covers a held-off access
  pready_bounded_a: assert property ($rose(penable) && psel |-> ##[1:40] pready) else $error("no answer");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
  gain_a_write_a: assert property (s_wr_at(12'h1e8) |=> chan_a_gain_adjust == $past(pwdata[7:0]))
    else $error("gain A write lost");
  bandgap_write_a: assert property (s_wr_at(12'h1f0) |=> bandgap_adjust == $past(pwdata[3:0]))
    else $error("band-gap write lost");
  dither_write_a: assert property (s_wr_at(12'h274) |=>
    {rounding_error_select, dither_size_select, dither_enable} == $past(pwdata[2:0])) else $error("dither write lost");
  bandgap_read_a: assert property (pready && !pwrite && paddr == 12'h1f0 |->
    prdata == {28'h000_0000, bandgap_adjust}) else $error("band-gap read wrong");
  dither_read_a: assert property (pready && !pwrite && paddr == 12'h274 |->
    prdata == {29'h0000_0000, rounding_error_select, dither_size_select, dither_enable}) else $error("dither read");
  unmapped_err_a: assert property (pready && paddr == 12'h000 |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped not refused");
  gain_b_hold_a: assert property ($changed(chan_b_gain_adjust) |-> $past(pready && pwrite) || $past(fuse_busy))
    else $error("gain B moved alone");
  fuse_load_a: assert property ($fell(fuse_busy) |-> chan_b_gain_adjust == fuse_gain_b)
    else $error("fuse not loaded");
endmodule

bind tdc_regs tdc_regs_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fuse_gain_b(fuse_gain_b), .chan_a_gain_adjust(chan_a_gain_adjust),
  .chan_b_gain_adjust(chan_b_gain_adjust), .bandgap_adjust(bandgap_adjust), .dither_enable(dither_enable),
  .dither_size_select(dither_size_select), .rounding_error_select(rounding_error_select), .fuse_busy(fuse_busy));

// ===== verification/trim_and_dither_config_regs_tb.sv
module trim_and_dither_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [38:0] fz = {8'ha5, 8'h3c, 4'h9, 8'h5a, 8'hc3, 3'h6};
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fuse_busy;
  wire [38:0] outs;
  int bad_count = 0;
  int checked = 0;

  // Small settle keeps the fuse load short
  tdc_regs #(.SETTLE(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuse_gain_a(fz[38:31]), .fuse_gain_b(fz[30:23]), .fuse_bandgap(fz[22:19]),
    .fuse_term_a(fz[18:11]), .fuse_term_b(fz[10:3]), .fuse_dither(fz[2:0]),
    .chan_a_gain_adjust(outs[38:31]), .chan_b_gain_adjust(outs[30:23]), .bandgap_adjust(outs[22:19]),
    .input_a_termination_adjust(outs[18:11]), .input_b_termination_adjust(outs[10:3]),
    .dither_enable(outs[0]), .dither_size_select(outs[1]), .rounding_error_select(outs[2]),
    .fuse_busy(fuse_busy));

  // Clock, 100 MHz
  always #5 pclk = ~pclk;

  // Field i of a packed trim vector, in register order
  function automatic logic [31:0] fld(input logic [38:0] v, input int i);
    case (i)
      0: fld = 32'(v[38:31]);
      1: fld = 32'(v[30:23]);
      2: fld = 32'(v[22:19]);
      3: fld = 32'(v[18:11]);
      4: fld = 32'(v[10:3]);
      default: fld = 32'(v[2:0]);
    endcase
  endfunction

  // Byte address of register i, in register order
  function automatic logic [11:0] adr(input int i);
    case (i)
      0: adr = 12'h1e8;
      1: adr = 12'h1ec;
      2: adr = 12'h1f0;
      3: adr = 12'h1f8;
      4: adr = 12'h1fc;
      default: adr = 12'h274;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  // One bus transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    r = prdata;
    e = pslverr;
    if (n >= 200) bad_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait for the fuse word to be applied
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (fuse_busy !== 1'b0 && n < 100);
    chk("fuse busy", 0, fuse_busy);
  endtask

  task automatic tally_and_finish();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Budget is five thousand cycles
  initial begin
    #50us;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] r;
    logic [31:0] d;
    logic e;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("fuse outputs", fz, outs);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, adr(i), 32'h0000_0000, r, e);
      chk("fuse read", fld(fz, i), r);
    end
    // Upper bits all set, so reserved bits must read back as zero
    for (int i = 0; i < 6; i++) begin
      d = 32'hffff_ff80 | 32'(i);
      apb(1'b1, adr(i), d, r, e);
      apb(1'b0, adr(i), 32'h0000_0000, r, e);
      chk("write read", d & fld('1, i), r);
      chk("write out", d & fld('1, i), fld(outs, i));
    end
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h274, 32'(k), r, e);
      // Field lands on the commit edge; look one edge later
      @(posedge pclk);
      chk("dither out", k, outs[2:0]);
    end
    apb(1'b1, 12'h1e9, 32'h0000_0011, r, e);
    chk("misaligned err", 1, e);
    chk("gain a kept", 32'h0000_0080, outs[38:31]);
    // Write with byte lane 0 off must leave the field alone
    pstrb <= 4'h0;
    apb(1'b1, 12'h1e8, 32'h0000_0011, r, e);
    pstrb <= 4'hf;
    @(posedge pclk);
    chk("strobe off kept", 32'h0000_0080, outs[38:31]);
    apb(1'b0, 12'h000, 32'h0000_0000, r, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, r);
    // Status flags every field written; reload restores the fuse word and clears them
    apb(1'b0, 12'h280, 32'h0000_0000, r, e);
    chk("status written", 32'h0000_3f00, r);
    apb(1'b1, 12'h284, 32'h0000_0001, r, e);
    apb(1'b0, 12'h280, 32'h0000_0000, r, e);
    chk("status reloaded", 0, r);
    chk("reload outs", fz, outs);
    // Second reset in mid-run must restore defaults, then the fuse word
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("reset state", 39'h00_0000_0001, outs);
    presetn <= 1'b1;
    settle();
    chk("reload", fz, outs);
    tally_and_finish();
  end
endmodule
